// ==== logic/balance_pkg.sv ====
// shared types and constants for the cell balance timer block
package balance_pkg;

    // register port widths
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;

    // register offsets
    localparam logic [ADDR_W-1:0] CTRL_ADDR = 8'h0D;
    localparam logic [ADDR_W-1:0] CELL_BAL_ADDR = 8'h13;
    localparam logic [ADDR_W-1:0] TIMER_BASE_ADDR = 8'h14;
    localparam logic [ADDR_W-1:0] POWER_DOWN_DELAY_ADDR = 8'h1A;
    localparam logic [ADDR_W-1:0] STATUS_ADDR = 8'h1B;

    // output count and field layouts
    localparam int NUM_OUT = 6;
    localparam int CB_LSB = 2;
    localparam int TMR_LSB = 3;
    localparam int TMR_W = 5;
    localparam int SW_PD_BIT = 8;
    localparam int CNT_W = 9;
    localparam int SUB_SHIFT = 4;

    // status register field positions
    localparam int ST_RUN_BIT = 15;
    localparam int ST_DOWN_BIT = 14;
    localparam int ST_PDACT_BIT = 13;

    // reset values
    localparam logic [NUM_OUT-1:0] CB_RESET = 6'h00;
    localparam logic [TMR_W-1:0] TMR_RESET = 5'h00;
    localparam logic [CNT_W-1:0] CNT_ZERO = 9'h000;
    localparam logic [CNT_W-1:0] CNT_ONE = 9'h001;

    // timing: comparison tick is one sixteenth of the 72 s step
    localparam longint CLOCK_PERIOD_NS = 10;
    localparam longint TICK_TIME_MS = 4500;
    localparam longint TICK_CYCLES_DEF = (TICK_TIME_MS * 64'd1000000) / CLOCK_PERIOD_NS;

    // register request carrier
    typedef struct packed {
        logic wr;
        logic rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } reg_req_t;

endpackage

// ==== logic/balance_slot.sv ====
// one output's expiry compare against the shared counter
`timescale 1ns/100ps
module balance_slot
    import balance_pkg::*;
(
    // compare inputs
    input wire logic i_on,
    input wire logic i_tick,
    input wire logic [CNT_W-1:0] i_count_next,
    input wire logic [TMR_W-1:0] i_limit,
    // result
    output logic o_expire
);

    logic [CNT_W-1:0] limit_ticks;

    // limit scaled to sixteenths; a zero limit never expires
    always_comb begin
        limit_ticks = CNT_W'(i_limit) << SUB_SHIFT;
        o_expire = i_on && (i_limit != TMR_RESET) && i_tick && (i_count_next >= limit_ticks);
    end

endmodule // balance_slot

// ==== logic/cell_balance_timer.sv ====
// cell balance outputs, shared balance timer and power-down delay
`timescale 1ns/100ps
module cell_balance_timer
    import balance_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = int'(TICK_CYCLES_DEF)
) (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_arst_n,
    // register port
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [DATA_W-1:0] o_rdata,
    // power-down pin, active low, asynchronous
    input wire logic i_power_down_pin_n,
    // balance gate outputs and power state
    output logic [NUM_OUT-1:0] o_balance_output,
    output logic o_powered_down
);

    ////////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        logic [1:0] pin_sync;
        logic pin_prev;
        logic [NUM_OUT-1:0] cb;
        logic [NUM_OUT-1:0][TMR_W-1:0] tmr;
        logic [TMR_W-1:0] pd_tmr;
        logic sw_pd;
        logic [31:0] presc;
        logic tick;
        logic run;
        logic [CNT_W-1:0] cnt;
        logic pd_act;
        logic [CNT_W-1:0] pd_cnt;
        logic down;
        logic [DATA_W-1:0] rdata;
    } state_t;

    localparam state_t STATE_RESET = '{
        pin_sync: 2'h3,
        pin_prev: 1'b1,
        cb: CB_RESET,
        tmr: '0,
        pd_tmr: TMR_RESET,
        sw_pd: 1'b0,
        presc: 32'h0000_0000,
        tick: 1'b0,
        run: 1'b0,
        cnt: CNT_ZERO,
        pd_act: 1'b0,
        pd_cnt: CNT_ZERO,
        down: 1'b0,
        rdata: 16'h0000
    };

    localparam logic [31:0] PRESC_LAST = 32'(TICK_CYCLES - 1);

    logic [1:0] rst_sync_q;
    logic rst_n;
    state_t q;
    state_t d;
    reg_req_t req;
    logic [CNT_W-1:0] cnt_next;
    logic [NUM_OUT-1:0] expire;

    ////////////////////////////////////////////////////////////////////////////
    // reset release: asserts at once, releases after two clean edges

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end

    assign rst_n = rst_sync_q[1];

    // bundle the register port
    assign req = '{wr: i_wr, rd: i_rd, addr: i_addr, wdata: i_wdata};

    ////////////////////////////////////////////////////////////////////////////
    // per-output expiry compares against the one shared counter

    assign cnt_next = CNT_W'(q.cnt + CNT_ONE);

    genvar gi;
    generate
        for (gi = 0; gi < NUM_OUT; gi++) begin : g_slot
            balance_slot u_slot (
                .i_on(q.cb[gi]),
                .i_tick(q.tick && q.run),
                .i_count_next(cnt_next),
                .i_limit(q.tmr[gi]),
                .o_expire(expire[gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // next-state logic

    always_comb begin
        logic pin_low;
        logic pin_fall;
        logic pd_start;
        logic pd_expire;
        logic any_timer;
        logic [NUM_OUT-1:0] new_cb;
        logic [NUM_OUT-1:0] timed;
        logic [TMR_W-1:0] new_tmr;
        logic [CNT_W-1:0] pd_next;
        logic [CNT_W-1:0] pd_limit;

        d = q;
        d.rdata = 16'h0000;
        pd_start = 1'b0;
        pd_expire = 1'b0;
        new_cb = req.wdata[CB_LSB +: NUM_OUT];
        new_tmr = req.wdata[TMR_LSB +: TMR_W];
        pd_next = CNT_W'(q.pd_cnt + CNT_ONE);
        timed = '0;
        pin_low = 1'b0;
        pin_fall = 1'b0;
        any_timer = 1'b0;
        pd_limit = CNT_ZERO;

        // pin passes two flops; only the second one is looked at
        d.pin_sync = {q.pin_sync[0], i_power_down_pin_n};
        d.pin_prev = q.pin_sync[1];
        pin_low = ~q.pin_sync[1];
        pin_fall = q.pin_prev & ~q.pin_sync[1];

        any_timer = 1'b0;
        for (int i = 0; i < NUM_OUT; i++) begin
            any_timer = any_timer | (q.tmr[i] != TMR_RESET);
        end

        // prescaler: one-cycle tick every 4.5 s
        d.tick = 1'b0;
        if (q.presc >= PRESC_LAST) begin
            d.presc = 32'h0000_0000;
            d.tick = 1'b1;
        end else begin
            d.presc = q.presc + 32'h0000_0001;
        end

        // shared counter advances by sixteenths; expired outputs drop
        if (q.tick && q.run) begin
            d.cnt = cnt_next;
        end
        d.cb = q.cb & ~expire;
        // timer registers are left untouched by expiry
        d.tmr = q.tmr;

        // host writes come after expiry so they win in the same cycle
        if (req.wr) begin
            if (req.addr == CELL_BAL_ADDR) begin
                d.cb = new_cb;
                // a running count is joined, never restarted
                if ((new_cb != CB_RESET) && any_timer && !q.run) begin
                    d.run = 1'b1;
                    d.cnt = CNT_ZERO;
                end
            end
            for (int i = 0; i < NUM_OUT; i++) begin
                if (req.addr == TIMER_BASE_ADDR + ADDR_W'(i)) begin
                    // writing a timer arms it; with its output on it also restarts the shared count
                    d.tmr[i] = new_tmr;
                    if (q.cb[i]) begin
                        // restart even when the count was idle, e.g. an untimed output
                        d.cnt = CNT_ZERO;
                        d.run = 1'b1;
                        if (new_tmr == TMR_RESET) begin
                            d.cb[i] = 1'b0;
                        end
                    end
                end
            end
            if (req.addr == POWER_DOWN_DELAY_ADDR) begin
                d.pd_tmr = new_tmr;
                // rewriting an active delay restarts its own count only, unless a tick lands in the same cycle and advances it instead
                if (q.pd_act) begin
                    d.pd_cnt = CNT_ZERO;
                end
            end
            if (req.addr == CTRL_ADDR) begin
                d.sw_pd = req.wdata[SW_PD_BIT];
                pd_start = req.wdata[SW_PD_BIT] & ~q.sw_pd;
            end
        end

        // balance counter stops once no timed output remains on
        for (int i = 0; i < NUM_OUT; i++) begin
            timed[i] = d.cb[i] && (d.tmr[i] != TMR_RESET);
        end
        if (d.run && (timed == CB_RESET)) begin
            d.run = 1'b0;
            d.cnt = CNT_ZERO;
        end

        // power-down delay: a later rising pin edge does not cancel it
        pd_start = pd_start | pin_fall;
        if (pd_start) begin
            d.pd_act = 1'b1;
            d.pd_cnt = CNT_ZERO;
        end
        pd_limit = CNT_W'(d.pd_tmr) << SUB_SHIFT;
        if (q.pd_act && !pd_start && q.tick) begin
            d.pd_cnt = pd_next;
        end
        // zero delay expires in the cycle it starts
        if (d.pd_act && ((d.pd_tmr == TMR_RESET) || (d.pd_cnt >= pd_limit))) begin
            pd_expire = 1'b1;
            d.pd_act = 1'b0;
        end

        // leave power-down once the pin is high and software bit clear
        if (q.down && !pin_low && !d.sw_pd) begin
            d.down = 1'b0;
        end
        // on expiry power down only if the pin (or software bit) still asks
        if (pd_expire && (pin_low || d.sw_pd)) begin
            d.down = 1'b1;
        end
        // powered down: every gate off and balance timing abandoned
        if (d.down) begin
            d.cb = CB_RESET;
            d.run = 1'b0;
            d.cnt = CNT_ZERO;
        end

        // reads: data stands in the cycle after the strobe only
        if (req.rd) begin
            if (req.addr == CELL_BAL_ADDR) begin
                d.rdata[CB_LSB +: NUM_OUT] = q.cb;
            end
            for (int i = 0; i < NUM_OUT; i++) begin
                if (req.addr == TIMER_BASE_ADDR + ADDR_W'(i)) begin
                    d.rdata[TMR_LSB +: TMR_W] = q.tmr[i];
                end
            end
            if (req.addr == POWER_DOWN_DELAY_ADDR) begin
                d.rdata[TMR_LSB +: TMR_W] = q.pd_tmr;
            end
            if (req.addr == CTRL_ADDR) begin
                d.rdata[SW_PD_BIT] = q.sw_pd;
            end
            if (req.addr == STATUS_ADDR) begin
                d.rdata[ST_RUN_BIT] = q.run;
                d.rdata[ST_DOWN_BIT] = q.down;
                d.rdata[ST_PDACT_BIT] = q.pd_act;
                d.rdata[CNT_W-1:0] = q.cnt;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            q <= STATE_RESET;
        end else begin
            q <= d;
        end
    end

    // outputs straight from flops
    assign o_balance_output = q.cb;
    assign o_powered_down = q.down;
    assign o_rdata = q.rdata;

endmodule // cell_balance_timer

// ==== testbench/balance_load.sv ====
// transistor load model that times each burst with any gate on
`timescale 1ns/100ps
module balance_load
    import balance_pkg::*;
(
    // gate drive and clock
    input wire logic i_clock,
    input wire logic [NUM_OUT-1:0] i_gate,
    // length of the last finished burst
    output logic [15:0] o_last
);
    logic [15:0] run_q = 16'h0000;
    ////////////////////////////////////////
    // drains only while a gate is on; keeps the last burst length
    always_ff @(posedge i_clock) begin
        if (|i_gate) begin
            run_q <= run_q + 16'h0001;
        end else begin
            if (run_q != 16'h0000) o_last <= run_q;
            run_q <= 16'h0000;
        end
    end
endmodule // balance_load

// ==== testbench/balance_monitor.sv ====
// port assertions for the cell balance timer
`timescale 1ns/100ps
module balance_monitor
    import balance_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = 4
) (
    // clock, reset, register port
    input wire logic i_clock,
    input wire logic i_arst_n,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [DATA_W-1:0] o_rdata,
    // pin and outputs
    input wire logic i_power_down_pin_n,
    input wire logic [NUM_OUT-1:0] o_balance_output,
    input wire logic o_powered_down
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_arst_n);
    logic pdz_q;
    ////////////////////////////////////////
    // zero delay decides whether the pin acts at once
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) pdz_q <= 1'b1;
        else if (i_wr && i_addr == POWER_DOWN_DELAY_ADDR) pdz_q <= (i_wdata[7:3] == 5'h00);
    end
    sequence s_cb_wr;
        i_wr && i_addr == CELL_BAL_ADDR && i_power_down_pin_n && !o_powered_down;
    endsequence
    sequence s_fall;
        $fell(i_power_down_pin_n);
    endsequence
    property p_cb_follow;
        s_cb_wr |=> o_balance_output == $past(i_wdata[7:2]);
    endproperty
    property p_rd_idle;
        !i_rd |=> o_rdata == 16'h0000;
    endproperty
    property p_pd_off;
        o_powered_down |-> o_balance_output == 6'h00;
    endproperty
    property p_on_by_write;
        |(o_balance_output & ~$past(o_balance_output)) |-> $past(i_wr && i_addr == CELL_BAL_ADDR);
    endproperty
    property p_pin_pd;
        s_fall ##0 pdz_q |-> ##[1:4] o_powered_down;
    endproperty
    property p_pd_pin_low;
        $rose(o_powered_down) |-> !$past(i_power_down_pin_n, 3) || !$past(i_power_down_pin_n, 4);
    endproperty
    property p_rst_off;
        $rose(i_arst_n) |-> (o_balance_output == 6'h00 && !o_powered_down) [*3];
    endproperty
    property p_pd_hold;
        s_fall ##0 !pdz_q |-> !o_powered_down [*8];
    endproperty
    a_cb_follow: assert property (p_cb_follow)
        else $error("outputs differ from written bits");
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data without read");
    a_pd_off: assert property (p_pd_off)
        else $error("output on while powered down");
    a_on_by_write: assert property (p_on_by_write)
        else $error("output on without balance write");
    a_pin_pd: assert property (p_pin_pd)
        else $error("no power-down after pin fall");
    a_pd_pin_low: assert property (p_pd_pin_low)
        else $error("power-down with pin high");
    a_rst_off: assert property (p_rst_off)
        else $error("outputs not off after reset");
    a_pd_hold: assert property (p_pd_hold)
        else $error("delay ignored");
endmodule // balance_monitor

bind cell_balance_timer balance_monitor #(.TICK_CYCLES(TICK_CYCLES)) u_balance_monitor (
    .i_clock(i_clock), .i_arst_n(i_arst_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_power_down_pin_n(i_power_down_pin_n),
    .o_balance_output(o_balance_output), .o_powered_down(o_powered_down));

// ==== testbench/tb.sv ====
// self-checking bench for the cell balance timer
`timescale 1ns/100ps
module tb;
    import balance_pkg::*;
    localparam int TK = 4;
    localparam int STEP = 16 * TK;
    localparam logic [7:0] T0 = TIMER_BASE_ADDR;
    typedef struct packed {logic [15:0] d; logic [5:0] e;} row_t;
    logic i_clock = 1'b0;
    logic i_arst_n = 1'b0;
    logic [7:0] i_addr = 8'h00;
    logic [15:0] i_wdata = 16'h0000;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic pin_n = 1'b1;
    logic [15:0] o_rdata;
    logic [5:0] outs;
    logic pd;
    logic [15:0] last_burst;
    int num_errors = 0;
    int samples_checked = 0;
    int cycles = 0;
    int n;
    row_t rows [6] = '{'{16'h0004, 6'h01}, '{16'h0008, 6'h02}, '{16'h0010, 6'h04},
        '{16'h0080, 6'h20}, '{16'hFF03, 6'h00}, '{16'h00FC, 6'h3F}};
    cell_balance_timer #(.TICK_CYCLES(TK)) u_cell_balance_timer (.i_clock(i_clock),
        .i_arst_n(i_arst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
        .i_rd(i_rd), .o_rdata(o_rdata), .i_power_down_pin_n(pin_n),
        .o_balance_output(outs), .o_powered_down(pd));
    balance_load u_balance_load (.i_clock(i_clock), .i_gate(outs), .o_last(last_burst));
    ////////////////////////////////////////
    // clock and hang guard
    initial begin
        forever #5 i_clock = ~i_clock;
    end
    always @(posedge i_clock) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            final_report();
        end
    end
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int c);
        repeat (c) @(posedge i_clock);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge i_clock);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clock);
        i_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e);
        @(posedge i_clock);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clock);
        i_rd <= 1'b0;
        #1;
        cmp(o_rdata & m, e);
    endtask
    // the pin moves on a rising edge like every other input
    task automatic set_pin(input logic v);
        @(posedge i_clock);
        pin_n <= v;
    endtask
    // counts edges until masked gates drop; a late or early drop is a mismatch
    task automatic wait_off(input logic [5:0] m, input int lo, input int hi);
        n = 0;
        while ((outs & m) != 6'h00 && n < hi + 8) begin
            tick(1);
            n++;
        end
        cmp({15'h0, n >= lo && n <= hi}, 16'h0001);
    endtask
    task automatic final_report();
        if (num_errors == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    ////////////////////////////////////////
    // reset, table rows, then timing and power-down cases
    initial begin
        repeat (10) @(posedge i_clock);
        i_arst_n <= 1'b1;
        tick(3);
        cmp({10'h0, outs}, 16'h0000);
        rd(T0, 16'h00F8, 16'h0000);
        foreach (rows[i]) begin
            wr(CELL_BAL_ADDR, rows[i].d);
            cmp({10'h0, outs}, {10'h0, rows[i].e});
            rd(CELL_BAL_ADDR, 16'h00FC, {8'h00, rows[i].e, 2'b00});
        end
        tick(3 * STEP);
        cmp({10'h0, outs}, 16'h003F);
        wr(CELL_BAL_ADDR, 16'h0000);
        wr(T0, 16'h0018);
        wr(T0 + 8'h01, 16'h0018);
        cmp({10'h0, outs}, 16'h0000);
        wr(CELL_BAL_ADDR, 16'h000C);
        tick(STEP);
        wr(T0 + 8'h02, 16'h0018);
        wr(CELL_BAL_ADDR, 16'h001C);
        wait_off(6'h01, 3 * STEP - 74, 3 * STEP - 63);
        cmp({10'h0, outs}, 16'h0000);
        rd(CELL_BAL_ADDR, 16'h00FC, 16'h0000);
        rd(T0 + 8'h02, 16'h00F8, 16'h0018);
        wr(CELL_BAL_ADDR, 16'h0004);
        wait_off(6'h01, 3 * STEP - 6, 3 * STEP + 3);
        wr(CELL_BAL_ADDR, 16'h000C);
        cmp({15'h0, last_burst >= 3 * STEP - 6 && last_burst <= 3 * STEP + 3}, 16'h0001);
        tick(STEP);
        wr(T0 + 8'h01, 16'h0018);
        wr(T0, 16'h0000);
        cmp({10'h0, outs}, 16'h0002);
        wait_off(6'h02, 3 * STEP - 6, 3 * STEP + 3);
        wr(CELL_BAL_ADDR, 16'h000C);
        wr(CELL_BAL_ADDR, 16'h0020);
        cmp({10'h0, outs}, 16'h0008);
        set_pin(1'b0);
        tick(6);
        cmp({9'h0, pd, outs}, 16'h0040);
        set_pin(1'b1);
        tick(6);
        rd(CELL_BAL_ADDR, 16'h00FC, 16'h0000);
        wr(POWER_DOWN_DELAY_ADDR, 16'h0008);
        wr(CELL_BAL_ADDR, 16'h0020);
        set_pin(1'b0);
        tick(STEP / 2);
        cmp({9'h0, pd, outs}, 16'h0008);
        wait_off(6'h08, STEP / 2 - 8, STEP / 2 + 8);
        cmp({15'h0, pd}, 16'h0001);
        set_pin(1'b1);
        tick(6);
        wr(CELL_BAL_ADDR, 16'h0020);
        set_pin(1'b0);
        tick(8);
        set_pin(1'b1);
        tick(2 * STEP);
        cmp({9'h0, pd, outs}, 16'h0008);
        // an untimed output that is given a time starts the count itself
        wr(T0 + 8'h03, 16'h0018);
        wait_off(6'h08, 3 * STEP - 6, 3 * STEP + 3);
        // software start with the pin high: delay runs, no power-down
        wr(CTRL_ADDR, 16'h0100);
        rd(STATUS_ADDR, 16'h2000, 16'h2000);
        rd(CTRL_ADDR, 16'h0100, 16'h0100);
        wr(CTRL_ADDR, 16'h0000);
        tick(2 * STEP);
        cmp({15'h0, pd}, 16'h0000);
        // reset with an untimed gate on drops the gates and clears the registers
        wr(CELL_BAL_ADDR, 16'h0004);
        @(posedge i_clock);
        i_arst_n <= 1'b0;
        tick(2);
        cmp({9'h0, pd, outs}, 16'h0000);
        @(posedge i_clock);
        i_arst_n <= 1'b1;
        tick(3);
        rd(T0 + 8'h01, 16'h00F8, 16'h0000);
        rd(CELL_BAL_ADDR, 16'h00FC, 16'h0000);
        final_report();
    end
endmodule // tb
